/* File: hw/sibdec_defs.vh */
`ifndef SIBDEC_DEFS_VH
`define SIBDEC_DEFS_VH
// Operand-specifier field codes
`define SIBDEC_MODE_NODISP 2'h0
`define SIBDEC_MODE_DISP8 2'h1
`define SIBDEC_MODE_DISP32 2'h2
`define SIBDEC_MODE_REG 2'h3
`define SIBDEC_RM_SIB 3'h4
`define SIBDEC_BASE_SP 3'h4
`define SIBDEC_BASE_BP 3'h5
`define SIBDEC_INDEX_NONE 3'h4
`define SIBDEC_SCALE_X1 2'h0
// Segment numbers: 0 extra, 1 code, 2 stack, 3 data, 4 extra_f, 5 extra_g
`define SIBDEC_SEG_STACK 3'h2
`define SIBDEC_SEG_DATA 3'h3
`define SIBDEC_SEG_LAST 3'h5
// Special-register classes
`define SIBDEC_CLASS_CTRL 2'h0
`define SIBDEC_CLASS_DEBUG 2'h1
`define SIBDEC_CLASS_TEST 2'h2
// Valid-code masks, bit n set when code n is valid
`define SIBDEC_CTRL_VALID 8'h0D
`define SIBDEC_DEBUG_VALID 8'hCF
`define SIBDEC_TEST_VALID 8'hF8
// Flag action codes
`define SIBDEC_FACT_KEEP 2'h0
`define SIBDEC_FACT_MOD 2'h1
`define SIBDEC_FACT_CLR 2'h2
`define SIBDEC_FACT_SET 2'h3
// Flag vector positions
`define SIBDEC_FLAG_CARRY 0
`define SIBDEC_FLAG_PARITY 1
`define SIBDEC_FLAG_AUX 2
`define SIBDEC_FLAG_ZERO 3
`define SIBDEC_FLAG_SIGN 4
`define SIBDEC_FLAG_TRAP 5
`define SIBDEC_FLAG_INTEN 6
`define SIBDEC_FLAG_DIR 7
`define SIBDEC_FLAG_OVF 8
`define SIBDEC_FLAG_COUNT 9
// Clock adders
`define SIBDEC_TWO_REG_CLKS 4'h1
`define SIBDEC_MISALIGN_ONE_CLKS 4'h2
`define SIBDEC_MISALIGN_BOTH_CLKS 4'h4
`endif

/* File: hw/sibdec_flag_unit.v */
`timescale 1ns/1ps
`include "sibdec_defs.vh"
module sibdec_flag_unit (
   input wire core_clk,
   input wire reset_n,
   input wire update,
   input wire [17:0] action,
   input wire [8:0] result_flags,
   output wire [8:0] flags
);
   reg [8:0] flags_ff;
   genvar i;
   generate
      for (i = 0; i < `SIBDEC_FLAG_COUNT; i = i + 1) begin : g_flag
         // Exactly one of four actions per flag
         always @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
               flags_ff[i] <= 1'b0;
            end else if (update) begin
               case (action[2*i+1:2*i])
                  `SIBDEC_FACT_MOD: flags_ff[i] <= result_flags[i];
                  `SIBDEC_FACT_CLR: flags_ff[i] <= 1'b0;
                  `SIBDEC_FACT_SET: flags_ff[i] <= 1'b1;
                  default: flags_ff[i] <= flags_ff[i];
               endcase
            end
         end
      end
   endgenerate
   assign flags = flags_ff;
endmodule // sibdec_flag_unit

/* File: hw/sibdec_decoder.v */
// How it works
// - With SIB, mode 00 base 101 gives 32-bit displacement, no base; base 100 stack.
// - Mode 01 adds sign-extended 8-bit, mode 10 32-bit displacement; 100/101 use stack segment.
// - Scale 00..11 multiplies index by 1, 2, 4, 8.
// - Index field picks general register; 100 means no index term.
// - No index needs scale 00; otherwise address undefined, producers avoid it.
// - Two-bit segment field: 00 extra, 01 code, 10 stack, 11 data.
// - Three-bit field adds 100/101 extra segments; 110/111 undefined.
// - Opcode gives special-register class; three-bit code gives number.
// - Valid: control 000,010,011; debug 000-011,110,111; test 011-111.
// - Nine status and control flags are tracked.
// - Each flag is modified, kept, cleared or set per instruction.
// - Baseline counts assume decoded instruction with no exception.
// - Bus wait or hold cycles extend execution one for one.
// - One register plus scale and displacement free; two registers add one clock unless the base field is 101.
// - Miss counts assume aligned 32-bit operands.
// - Misaligned operand adds 2 for read or write, 4 for both.
// - 32-bit mode/rm with rm 100 and mode not 11 brings a SIB byte.
`timescale 1ns/1ps
`include "sibdec_defs.vh"
module sibdec_decoder (
   input wire core_clk,
   input wire reset_n,
   input wire dec_valid,
   input wire addr32,
   input wire [7:0] modrm_byte,
   input wire [7:0] sib_byte,
   input wire [31:0] displacement,
   input wire [255:0] gpr_values,
   input wire [1:0] segment_select_two_bit,
   input wire [2:0] segment_select_three_bit,
   input wire use_three_bit_seg,
   input wire special_access,
   input wire [1:0] special_class,
   input wire [2:0] special_code,
   input wire [3:0] base_clocks,
   input wire read_op,
   input wire write_op,
   input wire misaligned,
   input wire exec_start,
   input wire bus_wait,
   input wire bus_hold,
   input wire flag_update,
   input wire [17:0] flag_action,
   input wire [8:0] result_flags,
   output reg sib_needed_ff,
   output reg [31:0] eff_addr_ff,
   output reg [2:0] addr_segment_ff,
   output reg has_base_ff,
   output reg has_index_ff,
   output reg addr_undefined_ff,
   output reg [2:0] segment_ff,
   output reg [1:0] spec_class_ff,
   output reg [2:0] spec_num_ff,
   output reg invalid_opcode_ff,
   output reg out_valid_ff,
   output reg [3:0] exec_clocks_ff,
   output reg exec_busy_ff,
   output reg exec_done_ff,
   output reg [8:0] flags_ff
);
   function [31:0] gpr;
      input [255:0] file;
      input [2:0] idx;
      begin
         gpr = file[idx*32 +: 32];
      end
   endfunction

   function spec_valid;
      input [1:0] cls;
      input [2:0] code;
      reg [7:0] mask;
      begin
         case (cls)
            `SIBDEC_CLASS_CTRL: mask = `SIBDEC_CTRL_VALID;
            `SIBDEC_CLASS_DEBUG: mask = `SIBDEC_DEBUG_VALID;
            `SIBDEC_CLASS_TEST: mask = `SIBDEC_TEST_VALID;
            default: mask = 8'h00;
         endcase
         spec_valid = mask[code];
      end
   endfunction

   wire [1:0] mode = modrm_byte[7:6];
   wire [2:0] rm = modrm_byte[2:0];
   wire [1:0] scale = sib_byte[7:6];
   wire [2:0] index = sib_byte[5:3];
   wire [2:0] base = sib_byte[2:0];
   wire sib_now = addr32 && rm == `SIBDEC_RM_SIB && mode != `SIBDEC_MODE_REG;
   wire [8:0] flag_state;

   reg [31:0] nxt_addr;
   reg [2:0] nxt_aseg;
   reg nxt_has_base;
   reg nxt_has_index;
   reg [31:0] disp_term;
   reg [31:0] base_term;
   reg [31:0] index_term;
   reg [2:0] nxt_seg;
   reg seg_bad;
   reg spec_bad;

   // SIB effective address
   always @* begin
      disp_term = 32'h00000000;
      base_term = gpr(gpr_values, base);
      nxt_has_base = 1'b1;
      nxt_aseg = `SIBDEC_SEG_DATA;
      case (mode)
         `SIBDEC_MODE_NODISP: begin
            if (base == `SIBDEC_BASE_BP) begin
               base_term = 32'h00000000;
               nxt_has_base = 1'b0;
               disp_term = displacement;
            end
            if (base == `SIBDEC_BASE_SP) begin
               nxt_aseg = `SIBDEC_SEG_STACK;
            end
         end
         `SIBDEC_MODE_DISP8: begin
            disp_term = {{24{displacement[7]}}, displacement[7:0]};
            if (base == `SIBDEC_BASE_SP || base == `SIBDEC_BASE_BP) begin
               nxt_aseg = `SIBDEC_SEG_STACK;
            end
         end
         `SIBDEC_MODE_DISP32: begin
            disp_term = displacement;
            if (base == `SIBDEC_BASE_SP || base == `SIBDEC_BASE_BP) begin
               nxt_aseg = `SIBDEC_SEG_STACK;
            end
         end
         default: begin
            base_term = 32'h00000000;
            nxt_has_base = 1'b0;
         end
      endcase
      nxt_has_index = index != `SIBDEC_INDEX_NONE;
      if (nxt_has_index) begin
         index_term = gpr(gpr_values, index) << scale;
      end else begin
         index_term = 32'h00000000;
      end
      nxt_addr = base_term + index_term + disp_term;
   end

   // Segment and special-register selectors
   always @* begin
      seg_bad = 1'b0;
      if (use_three_bit_seg) begin
         nxt_seg = segment_select_three_bit;
         seg_bad = segment_select_three_bit > `SIBDEC_SEG_LAST;
      end else begin
         nxt_seg = {1'b0, segment_select_two_bit};
      end
      spec_bad = special_access && !spec_valid(special_class, special_code);
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sib_needed_ff <= 1'b0;
         eff_addr_ff <= 32'h00000000;
         addr_segment_ff <= `SIBDEC_SEG_DATA;
         has_base_ff <= 1'b0;
         has_index_ff <= 1'b0;
         addr_undefined_ff <= 1'b0;
         segment_ff <= 3'h0;
         spec_class_ff <= 2'h0;
         spec_num_ff <= 3'h0;
         invalid_opcode_ff <= 1'b0;
         out_valid_ff <= 1'b0;
      end else begin
         out_valid_ff <= dec_valid;
         if (dec_valid) begin
            sib_needed_ff <= sib_now;
            eff_addr_ff <= nxt_addr;
            addr_segment_ff <= nxt_aseg;
            has_base_ff <= nxt_has_base;
            has_index_ff <= nxt_has_index;
            addr_undefined_ff <= !nxt_has_index && scale != `SIBDEC_SCALE_X1;
            segment_ff <= seg_bad ? 3'h0 : nxt_seg;
            spec_class_ff <= special_class;
            spec_num_ff <= spec_bad ? 3'h0 : special_code;
            invalid_opcode_ff <= seg_bad || spec_bad;
         end
      end
   end

   // Execution clock budget
   reg [3:0] nxt_clocks;
   reg [3:0] run_cnt_ff;
   always @* begin
      nxt_clocks = base_clocks;
      if (sib_now && base != `SIBDEC_BASE_BP && index != `SIBDEC_INDEX_NONE) begin
         nxt_clocks = nxt_clocks + `SIBDEC_TWO_REG_CLKS;
      end
      if (misaligned) begin
         if (read_op && write_op) begin
            nxt_clocks = nxt_clocks + `SIBDEC_MISALIGN_BOTH_CLKS;
         end else if (read_op || write_op) begin
            nxt_clocks = nxt_clocks + `SIBDEC_MISALIGN_ONE_CLKS;
         end
      end
   end

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         exec_clocks_ff <= 4'h0;
         run_cnt_ff <= 4'h0;
         exec_busy_ff <= 1'b0;
         exec_done_ff <= 1'b0;
      end else begin
         exec_done_ff <= 1'b0;
         if (exec_start && !exec_busy_ff) begin
            exec_clocks_ff <= nxt_clocks;
            run_cnt_ff <= nxt_clocks;
            exec_busy_ff <= nxt_clocks != 4'h0;
            exec_done_ff <= nxt_clocks == 4'h0;
         end else if (exec_busy_ff && !bus_wait && !bus_hold) begin
            run_cnt_ff <= run_cnt_ff - 4'h1;
            if (run_cnt_ff == 4'h1) begin
               exec_busy_ff <= 1'b0;
               exec_done_ff <= 1'b1;
            end
         end
      end
   end

   sibdec_flag_unit u_flags (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .update(flag_update),
      .action(flag_action),
      .result_flags(result_flags),
      .flags(flag_state)
   );

   always @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_ff <= 9'h000;
      end else begin
         flags_ff <= flag_state;
      end
   end
endmodule // sibdec_decoder

/* File: dv/sibdec_sva.sv */
`timescale 1ns/1ps
module sibdec_sva (
   input logic core_clk,
   input logic reset_n,
   input logic dec_valid,
   input logic addr32,
   input logic [7:0] modrm_byte,
   input logic [7:0] sib_byte,
   input logic use_three_bit_seg,
   input logic [1:0] segment_select_two_bit,
   input logic [2:0] segment_select_three_bit,
   input logic special_access,
   input logic [1:0] special_class,
   input logic [2:0] special_code,
   input logic flag_update,
   input logic [17:0] flag_action,
   input logic out_valid_ff,
   input logic sib_needed_ff,
   input logic has_index_ff,
   input logic addr_undefined_ff,
   input logic [2:0] addr_segment_ff,
   input logic [2:0] segment_ff,
   input logic invalid_opcode_ff,
   input logic exec_busy_ff,
   input logic exec_done_ff,
   input logic [8:0] flags_ff
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   logic [7:0] vmask;
   assign vmask = special_class == 2'h0 ? 8'h0D : special_class == 2'h1 ? 8'hCF : special_class == 2'h2 ? 8'hF8 : 8'h00;
   a_sib_detect: assert property (dec_valid |=> out_valid_ff && sib_needed_ff ==
      ($past(addr32) && $past(modrm_byte[2:0]) == 3'h4 && $past(modrm_byte[7:6]) != 2'h3)) else $error("sib detect");
   a_index_none: assert property (dec_valid |=> has_index_ff == ($past(sib_byte[5:3]) != 3'h4))
      else $error("index term");
   a_scale_undef: assert property (dec_valid && sib_byte[5:3] == 3'h4 && sib_byte[7:6] != 2'h0
      |=> addr_undefined_ff) else $error("undefined address");
   a_seg_two: assert property (dec_valid && !use_three_bit_seg |=>
      segment_ff == {1'b0, $past(segment_select_two_bit)}) else $error("two bit segment");
   a_seg_undef: assert property (dec_valid && use_three_bit_seg && segment_select_three_bit[2:1] == 2'h3
      |=> invalid_opcode_ff && segment_ff == 3'h0) else $error("undefined segment");
   a_spec_invalid: assert property (dec_valid && special_access && !vmask[special_code]
      |=> invalid_opcode_ff) else $error("special code");
   a_base_stack: assert property (dec_valid && sib_byte[2:0] == 3'h4 && modrm_byte[7:6] != 2'h3
      |=> addr_segment_ff == 3'h2) else $error("stack base segment");
   a_done_bound: assert property ($rose(exec_busy_ff) |-> ##[1:60] exec_done_ff)
      else $error("no done");
   a_done_end: assert property ($fell(exec_busy_ff) |-> exec_done_ff ##1 !exec_done_ff)
      else $error("done pulse");
   a_flag_clear: assert property (flag_update && flag_action[1:0] == 2'h2 ##1 !flag_update
      |=> !flags_ff[0]) else $error("flag clear");
   cover property (dec_valid ##1 sib_needed_ff);
   cover property (exec_done_ff);
   cover property (invalid_opcode_ff);
endmodule // sibdec_sva
bind sibdec_decoder sibdec_sva i_sibdec_sva (.*);

/* File: dv/sibdec_exec_partner.sv */
`timescale 1ns/1ps
module sibdec_exec_partner (
   input logic core_clk,
   input logic exec_busy_ff,
   input logic [3:0] stall_n,
   output logic bus_wait,
   output logic bus_hold
);
   logic [3:0] left_ff;
   initial begin
      bus_wait = 1'b0;
      bus_hold = 1'b0;
      left_ff = 4'h0;
   end
   // Wait and hold cycles alternate for the first stall_n cycles of an operation, then stop
   always @(negedge core_clk) begin
      bus_wait <= exec_busy_ff && left_ff != 4'h0 && left_ff[0];
      bus_hold <= exec_busy_ff && left_ff != 4'h0 && !left_ff[0];
      if (!exec_busy_ff) left_ff <= stall_n;
      else if (left_ff != 4'h0) left_ff <= left_ff - 4'h1;
   end
endmodule // sibdec_exec_partner

/* File: dv/sib_operand_field_decoder_tb.sv */
`timescale 1ns/1ps
module sib_operand_field_decoder_tb;
   logic core_clk, reset_n, dec_valid, addr32, use_three_bit_seg, special_access, read_op, write_op;
   logic misaligned, exec_start, flag_update, e_sib, e_base, e_idx, e_und, e_inv, e_m3, e_sok;
   logic [7:0] modrm_byte, sib_byte, mask;
   logic [31:0] displacement, rs, r, e_ea;
   logic [255:0] gpr_values;
   logic [1:0] segment_select_two_bit, special_class, md;
   logic [2:0] segment_select_three_bit, special_code, b, x, sg, e_sa, e_sg;
   logic [3:0] base_clocks, stall_n;
   logic [17:0] flag_action;
   logic [8:0] result_flags, fm;
   wire bus_wait, bus_hold, sib_needed_ff, has_base_ff, has_index_ff, addr_undefined_ff, invalid_opcode_ff;
   wire out_valid_ff, exec_busy_ff, exec_done_ff;
   wire [31:0] eff_addr_ff;
   wire [2:0] addr_segment_ff, segment_ff, spec_num_ff;
   wire [1:0] spec_class_ff;
   wire [3:0] exec_clocks_ff;
   wire [8:0] flags_ff;
   int n_mismatch, num_checks, i, k, lat, n;
   sibdec_decoder i_sibdec_decoder (.*);
   sibdec_exec_partner i_sibdec_exec_partner (.*);
   function automatic logic [31:0] rnd();
      repeat (32) rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
      return rs;
   endfunction
   function automatic logic [31:0] gpr(input logic [2:0] g);
      return gpr_values[g*32+:32];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic run_exec(input logic [3:0] bc, input logic [2:0] rwm, input logic [7:0] mr, input logic [7:0] sb,
      input logic [3:0] st);
      // Stall count settles a cycle ahead so the partner loads it before busy rises
      stall_n = st;
      @(negedge core_clk);
      {base_clocks, read_op, write_op, misaligned, modrm_byte, sib_byte} = {bc, rwm, mr, sb};
      addr32 = 1'b1;
      exec_start = 1'b1;
      n = bc + (mr[2:0] == 3'h4 && mr[7:6] != 2'h3 && sb[2:0] != 3'h5 && sb[5:3] != 3'h4);
      if (rwm[0]) n += (rwm[2] && rwm[1]) ? 4 : (rwm[2] || rwm[1]) ? 2 : 0;
      @(negedge core_clk);
      exec_start = 1'b0;
      chk(exec_clocks_ff, n);
      lat = 1;
      while (!exec_done_ff && lat < 100) begin
         @(negedge core_clk);
         lat++;
         exec_start = exec_busy_ff;
      end
      exec_start = 1'b0;
      chk(lat, n + 1 + st);
      if (lat >= 100) wrap_up();
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      rs = 32'h00008E0B;
      {reset_n, dec_valid, addr32, use_three_bit_seg, special_access, read_op, write_op, misaligned} = 8'h00;
      {exec_start, flag_update, modrm_byte, sib_byte, displacement, gpr_values} = '0;
      {segment_select_two_bit, special_class, segment_select_three_bit, special_code} = 10'h000;
      {base_clocks, stall_n, flag_action, result_flags, fm} = '0;
      repeat (16) @(posedge core_clk);
      @(negedge core_clk);
      reset_n = 1'b1;
      chk({addr_segment_ff, out_valid_ff, flags_ff}, {3'h3, 1'b0, 9'h000});
      for (i = 0; i <= 40; i++) begin
         @(negedge core_clk);
         if (i > 0) begin
            chk({out_valid_ff, sib_needed_ff}, {1'b1, e_sib});
            chk({has_base_ff, has_index_ff}, {e_base, e_idx});
            chk(addr_undefined_ff, e_und);
            if (!e_und) chk(eff_addr_ff, e_ea);
            if (!e_m3) chk(addr_segment_ff, e_sa);
            chk({invalid_opcode_ff, segment_ff}, {e_inv, e_sg});
            if (e_sok) chk({spec_class_ff, spec_num_ff}, {special_class, special_code});
         end
         dec_valid = i < 40;
         r = rnd();
         {special_code, special_class, segment_select_three_bit, segment_select_two_bit, special_access,
            use_three_bit_seg, addr32, sib_byte, modrm_byte} = r[28:0];
         displacement = rnd();
         for (k = 0; k < 8; k++) gpr_values[k*32+:32] = rnd();
         if (sib_byte[5:3] == 3'h4 && r[31:29] != 3'h0) sib_byte[7:6] = 2'h0;
         {md, b, x} = {modrm_byte[7:6], sib_byte[2:0], sib_byte[5:3]};
         e_sib = addr32 && modrm_byte[2:0] == 3'h4 && md != 2'h3;
         e_m3 = md == 2'h3;
         e_base = !e_m3 && !(md == 2'h0 && b == 3'h5);
         e_idx = x != 3'h4;
         e_und = !e_idx && sib_byte[7:6] != 2'h0;
         e_ea = (e_base ? gpr(b) : 32'h0) + (e_idx ? gpr(x) << sib_byte[7:6] : 32'h0);
         if (md == 2'h1) e_ea += {{24{displacement[7]}}, displacement[7:0]};
         else if (md == 2'h2 || !e_base && !e_m3) e_ea += displacement;
         e_sa = (b == 3'h4 || b == 3'h5 && md != 2'h0) ? 3'h2 : 3'h3;
         sg = use_three_bit_seg ? segment_select_three_bit : {1'b0, segment_select_two_bit};
         mask = special_class == 2'h0 ? 8'h0D : special_class == 2'h1 ? 8'hCF : special_class == 2'h2 ? 8'hF8 : 8'h00;
         e_sok = special_access && mask[special_code];
         e_inv = use_three_bit_seg && sg[2:1] == 2'h3 || special_access && !mask[special_code];
         e_sg = (use_three_bit_seg && sg[2:1] == 2'h3) ? 3'h0 : sg;
      end
      run_exec(4'h2, 3'b000, 8'h44, 8'h08, 4'h0);
      run_exec(4'h1, 3'b101, 8'hC0, 8'h08, 4'h3);
      run_exec(4'h1, 3'b011, 8'h04, 8'h25, 4'h0);
      run_exec(4'h3, 3'b111, 8'h84, 8'h21, 4'h2);
      run_exec(4'h0, 3'b110, 8'h00, 8'h00, 4'h0);
      run_exec(4'h5, 3'b111, 8'h04, 8'h00, 4'h5);
      for (i = 0; i < 10; i++) begin
         @(negedge core_clk);
         r = rnd();
         {result_flags, flag_action} = r[26:0];
         flag_update = 1'b1;
         for (k = 0; k < 9; k++) fm[k] = r[2*k+:2] == 2'h1 ? r[18+k] : r[2*k+:2] == 2'h0 ? fm[k] : r[2*k];
         @(negedge core_clk);
         flag_update = 1'b0;
         repeat (2) @(negedge core_clk);
         chk(flags_ff, fm);
      end
      wrap_up();
   end
endmodule // sib_operand_field_decoder_tb
